/* File: inc/spi_nvm_pkg.sv */
// shared constants for the serial memory command link
package spi_nvm_pkg;
	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_STATUS_LOAD_FIRST = 8'h01;
	localparam logic [7:0] OP_ARRAY_PROGRAM = 8'h02;
	localparam logic [7:0] OP_ARRAY_FETCH = 8'h03;
	localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
	localparam logic [7:0] OP_STATUS_FETCH = 8'h05;
	localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
	localparam logic [7:0] OP_FAST_ARRAY_FETCH = 8'h0B;
	localparam logic [7:0] OP_STATUS_LOAD_SECOND = 8'h31;
	localparam logic [7:0] OP_PAGE_ERASE = 8'h42;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
	localparam logic [7:0] OP_OTP_FETCH = 8'h77;
	localparam logic [7:0] OP_ULTRA_DEEP_SLEEP = 8'h79;
	localparam logic [7:0] OP_OTP_PROGRAM = 8'h9B;
	localparam logic [7:0] OP_WAKE_FROM_SLEEP = 8'hAB;
	localparam logic [7:0] OP_SLEEP_ENTER = 8'hB9;
	// ----------------------------------------------------------------
	// status byte one fields and byte two masks
	// ----------------------------------------------------------------
	localparam int BUSY_FLAG_BIT = 0;
	localparam int WRITE_ENABLE_LATCH_BIT = 1;
	localparam int BLOCK_PROTECT_LO_BIT = 2;
	localparam int BLOCK_PROTECT_HI_BIT = 3;
	localparam int ULTRA_DEEP_BIT = 4;
	localparam int LOW_POWER_IDLE_ENABLE_BIT = 5;
	localparam int AUTO_SLEEP_ENABLE_BIT = 6;
	localparam int STATUS_LOCK_ENABLE_BIT = 7;
	localparam logic [7:0] STATUS_ONE_WRITABLE = 8'hEC;
	localparam logic [7:0] STATUS_ONE_RESET = 8'h00;
	localparam logic [7:0] STATUS_TWO_WRITABLE = 8'h03;
	localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
	// ----------------------------------------------------------------
	// framing counts
	// ----------------------------------------------------------------
	localparam int ADDR_BYTES = 2;
	localparam int FAST_DUMMY_BYTES = 1;
	localparam int PAGE_BYTES = 32;
	localparam int OTP_PROGRAM_BYTES = 3;
	localparam int OTP_BYTES = 64;
	localparam int BUSY_CYCLES = 64;
	// half period in pclk: the full period, twice this, is longer than the device answer's trip through both synchronisers
	localparam int SCK_HALF_DIV = 6;
	// ----------------------------------------------------------------
	// controller registers (apb byte offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TXDATA = 8'h04;
	localparam logic [7:0] REG_RXDATA = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam int CTRL_SELECT_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
endpackage : spi_nvm_pkg

/* File: inc/spi_nvm_if.sv */
// serial link between controller and memory device
`timescale 1ns/1ns
interface spi_nvm_if;
	logic cs_n;
	logic sck;
	logic sdi;
	logic sdo_o;
	logic sdo_oe_n;
	logic wp_n;
	logic sdo;
	assign sdo = sdo_oe_n ? 1'b1 : sdo_o;
	modport device (input cs_n, input sck, input sdi, input wp_n, output sdo_o, output sdo_oe_n);
	modport master (output cs_n, output sck, output sdi, output wp_n, input sdo);
endinterface : spi_nvm_if

/* File: hw/spi_nvm_device.sv */
// memory device end: command decode and status registers
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// RULE_01: opcode captured in eight-bit instruction register
// RULE_02: all bytes move MSB first
// RULE_03: first bit on first rise after select
// RULE_04: 03H read: two address bytes, stream
// RULE_05: 0BH read: address, one dummy, stream
// RULE_06: 06H sets latch, 04H clears, 02H programs
// RULE_07: 01H, 31H write status bytes one, two
// RULE_08: status read always honoured, repeats; the code refuses it in sleep and ultra-deep sleep
// RULE_09: busy and latch in first byte
// RULE_10: bit 0 busy during program or erase
// RULE_11: bit 1 is write-enable latch
// RULE_12: bits 2,3 block protection
// RULE_13: bit 4 set in ultra-deep sleep
// RULE_14: master may poll bit 0 for ready
// RULE_15: bit 5 low-power idle enable
// RULE_16: bit 6 auto sleep enable
// RULE_17: bit 7 with pin locks status
// RULE_18: otp program three bytes, 77H fetch
// RULE_19: erase, sleep and wake opcodes accepted
// RULE_20: sample on rise, drive on fall
// RULE_21: writes need latch set beforehand
// RULE_22: deselected: ignore input, output released
module spi_nvm_device
	import spi_nvm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	spi_nvm_if.device link,
	output logic [7:0] opcode,
	output logic [15:0] address,
	output logic [7:0] wr_data,
	output logic wr_strobe,
	input wire logic [7:0] rd_data,
	output logic [7:0] status_one,
	output logic [7:0] status_two
);
	typedef enum {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DATA, PH_IGNORE} phase_type;
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] cs_sync_reg, sck_sync_reg, sdi_sync_reg, wp_sync_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_sync_reg <= 3'h7;
			sck_sync_reg <= 3'h0;
			sdi_sync_reg <= 3'h0;
			wp_sync_reg <= 3'h7;
		end else begin
			cs_sync_reg <= {cs_sync_reg[1:0], link.cs_n};
			sck_sync_reg <= {sck_sync_reg[1:0], link.sck};
			sdi_sync_reg <= {sdi_sync_reg[1:0], link.sdi};
			wp_sync_reg <= {wp_sync_reg[1:0], link.wp_n};
		end
	end
	logic cs_f_reg, sck_f_reg, sdi_f_reg, wp_f_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs_f_reg <= 1'b1;
			sck_f_reg <= 1'b0;
			sdi_f_reg <= 1'b0;
			wp_f_reg <= 1'b1;
		end else begin
			if (cs_sync_reg[1] == cs_sync_reg[2]) cs_f_reg <= cs_sync_reg[2];
			if (sck_sync_reg[1] == sck_sync_reg[2]) sck_f_reg <= sck_sync_reg[2];
			if (sdi_sync_reg[1] == sdi_sync_reg[2]) sdi_f_reg <= sdi_sync_reg[2];
			if (wp_sync_reg[1] == wp_sync_reg[2]) wp_f_reg <= wp_sync_reg[2];
		end
	end
	logic sck_prev_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sck_prev_reg <= 1'b0;
		else sck_prev_reg <= sck_f_reg;
	end
	logic selected, sck_rise, sck_fall;
	assign selected = !cs_f_reg;
	assign sck_rise = selected && sck_f_reg && !sck_prev_reg; // RULE_03 RULE_20
	assign sck_fall = selected && !sck_f_reg && sck_prev_reg; // RULE_20
	// ----------------------------------------------------------------
	// byte assembly
	// ----------------------------------------------------------------
	logic [2:0] bit_cnt_reg;
	logic [7:0] shift_in_reg;
	logic byte_done;
	logic [7:0] byte_in;
	assign byte_in = {shift_in_reg[6:0], sdi_f_reg}; // RULE_02
	assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_cnt_reg <= 3'h0;
			shift_in_reg <= 8'h00;
		end else if (!selected) begin
			bit_cnt_reg <= 3'h0; // RULE_22
		end else if (sck_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			shift_in_reg <= byte_in;
		end
	end
	// ----------------------------------------------------------------
	// command sequencing
	// ----------------------------------------------------------------
	phase_type phase_reg;
	logic [7:0] opcode_reg;
	logic [6:0] count_reg;
	logic [15:0] addr_reg;
	logic [7:0] status_one_reg, status_two_reg;
	logic latch_reg, busy_reg, deep_reg, sleep_reg;
	logic [6:0] busy_cnt_reg;
	logic [7:0] wr_data_reg;
	logic wr_strobe_reg;
	logic [7:0] pend_op_reg;
	logic [5:0] pend_cnt_reg;
	logic [7:0] pend_data_reg;
	logic status_locked, was_selected_reg, frame_end;
	assign status_locked = status_one_reg[STATUS_LOCK_ENABLE_BIT] && !wp_f_reg; // RULE_17
	assign frame_end = was_selected_reg && !selected;
	function automatic logic needs_addr(input logic [7:0] op);
		needs_addr = (op == OP_ARRAY_FETCH) || (op == OP_FAST_ARRAY_FETCH) ||
			(op == OP_ARRAY_PROGRAM) || (op == OP_PAGE_ERASE);
	endfunction : needs_addr
	// sleep takes only the wake opcode; ultra-deep sleep takes nothing
	function automatic logic refused(input logic deep, input logic sleep, input logic [7:0] op);
		refused = deep || (sleep && op != OP_WAKE_FROM_SLEEP);
	endfunction : refused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) was_selected_reg <= 1'b0;
		else was_selected_reg <= selected;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= PH_OPCODE;
			opcode_reg <= 8'h00;
			count_reg <= 7'h00;
			addr_reg <= 16'h0000;
		end else if (!selected) begin
			phase_reg <= PH_OPCODE;
			count_reg <= 7'h00;
		end else if (byte_done) begin
			case (phase_reg)
				PH_OPCODE: begin
					opcode_reg <= byte_in; // RULE_01
					count_reg <= 7'h00;
					if (refused(deep_reg, sleep_reg, byte_in)) phase_reg <= PH_IGNORE; // RULE_19
					else if (needs_addr(byte_in)) phase_reg <= PH_ADDR; // RULE_04 RULE_05
					else phase_reg <= PH_DATA;
				end
				PH_ADDR: begin
					addr_reg <= {addr_reg[7:0], byte_in};
					count_reg <= count_reg + 7'h01;
					if (count_reg == 7'(ADDR_BYTES - 1)) begin
						count_reg <= 7'h00;
						phase_reg <= (opcode_reg == OP_FAST_ARRAY_FETCH) ? PH_DUMMY : PH_DATA;
					end
				end
				PH_DUMMY: begin
					count_reg <= count_reg + 7'h01;
					if (count_reg == 7'(FAST_DUMMY_BYTES - 1)) begin
						count_reg <= 7'h00;
						phase_reg <= PH_DATA; // RULE_05
					end
				end
				PH_DATA: begin
					if (count_reg != 7'h7F) count_reg <= count_reg + 7'h01;
					if (opcode_reg == OP_ARRAY_FETCH || opcode_reg == OP_FAST_ARRAY_FETCH ||
						opcode_reg == OP_ARRAY_PROGRAM) addr_reg <= addr_reg + 16'h0001;
				end
				default: phase_reg <= PH_IGNORE;
			endcase
		end
	end
	// data bytes handed out as strobes; writes commit at frame end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_strobe_reg <= 1'b0;
			wr_data_reg <= 8'h00;
		end else begin
			wr_strobe_reg <= byte_done && phase_reg == PH_DATA && latch_reg && !busy_reg &&
				opcode_reg == OP_ARRAY_PROGRAM && count_reg < 7'(PAGE_BYTES); // RULE_06 RULE_21
			if (byte_done && phase_reg == PH_DATA) wr_data_reg <= byte_in;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_op_reg <= 8'h00;
			pend_cnt_reg <= 6'h00;
			pend_data_reg <= 8'h00;
		end else if (!selected) begin
			pend_op_reg <= frame_end ? pend_op_reg : 8'h00;
		end else if (sck_rise && phase_reg != PH_IGNORE) begin
			if (byte_done && phase_reg == PH_OPCODE) begin
				pend_op_reg <= refused(deep_reg, sleep_reg, byte_in) ? 8'h00 : byte_in; // RULE_19
				pend_cnt_reg <= 6'h00;
			end else if (byte_done && phase_reg == PH_DATA) begin
				if (pend_cnt_reg != 6'h3F) pend_cnt_reg <= pend_cnt_reg + 6'h01;
				if (pend_cnt_reg == 6'h00) pend_data_reg <= byte_in;
			end else if (byte_done && phase_reg == PH_ADDR &&
				count_reg == 7'(ADDR_BYTES - 1)) begin
				pend_cnt_reg <= 6'h00;
			end
		end else if (sck_rise) begin
			pend_op_reg <= 8'h00;
		end
	end
	// commit only whole commands: bit count back at a byte boundary
	logic whole;
	assign whole = frame_end && bit_cnt_reg == 3'h0;
	logic is_prog, is_status1, is_status2, is_write_cmd, start_busy;
	assign is_prog = (pend_op_reg == OP_ARRAY_PROGRAM && pend_cnt_reg != 6'h00) ||
		pend_op_reg == OP_PAGE_ERASE || pend_op_reg == OP_CHIP_ERASE_A ||
		pend_op_reg == OP_CHIP_ERASE_B || (pend_op_reg == OP_OTP_PROGRAM &&
		pend_cnt_reg == 6'(OTP_PROGRAM_BYTES)); // RULE_18 RULE_19
	assign is_status1 = pend_op_reg == OP_STATUS_LOAD_FIRST && pend_cnt_reg == 6'h01; // RULE_07
	assign is_status2 = pend_op_reg == OP_STATUS_LOAD_SECOND && pend_cnt_reg == 6'h01; // RULE_07
	assign is_write_cmd = is_prog || is_status1 || is_status2;
	assign start_busy = whole && latch_reg && !busy_reg && is_write_cmd; // RULE_21
	// ----------------------------------------------------------------
	// status state
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_reg <= 1'b0;
		end else if (whole && !busy_reg) begin
			if (pend_op_reg == OP_SET_WRITE_LATCH) latch_reg <= 1'b1; // RULE_06
			else if (pend_op_reg == OP_CLEAR_WRITE_LATCH) latch_reg <= 1'b0; // RULE_06
			else if (start_busy) latch_reg <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			busy_cnt_reg <= 7'h00;
		end else if (start_busy) begin
			busy_reg <= 1'b1; // RULE_10
			busy_cnt_reg <= 7'(BUSY_CYCLES - 1);
		end else if (busy_reg) begin
			busy_cnt_reg <= busy_cnt_reg - 7'h01;
			if (busy_cnt_reg == 7'h00) busy_reg <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_one_reg <= STATUS_ONE_RESET;
			status_two_reg <= STATUS_TWO_RESET;
		end else if (start_busy && !status_locked) begin
			if (is_status1) status_one_reg <= pend_data_reg & STATUS_ONE_WRITABLE; // RULE_12 RULE_15 RULE_16 RULE_17
			if (is_status2) status_two_reg <= pend_data_reg & STATUS_TWO_WRITABLE;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deep_reg <= 1'b0;
			sleep_reg <= 1'b0;
		end else if (whole && !busy_reg) begin
			if (pend_op_reg == OP_ULTRA_DEEP_SLEEP) deep_reg <= 1'b1; // RULE_13 RULE_19
			if (pend_op_reg == OP_SLEEP_ENTER) sleep_reg <= 1'b1;
			if (pend_op_reg == OP_WAKE_FROM_SLEEP) sleep_reg <= 1'b0; // RULE_19
		end
	end
	logic [7:0] status_view;
	always_comb begin
		status_view = status_one_reg;
		status_view[BUSY_FLAG_BIT] = busy_reg; // RULE_09 RULE_10
		status_view[WRITE_ENABLE_LATCH_BIT] = latch_reg; // RULE_09 RULE_11
		status_view[ULTRA_DEEP_BIT] = deep_reg; // RULE_13
	end
	// ----------------------------------------------------------------
	// output shifter
	// ----------------------------------------------------------------
	logic [7:0] shift_out_reg;
	logic sdo_reg, sdo_oe_n_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_out_reg <= 8'h00;
			sdo_reg <= 1'b0;
			sdo_oe_n_reg <= 1'b1;
		end else if (!selected || deep_reg) begin
			sdo_oe_n_reg <= 1'b1; // RULE_22
		end else if (sck_fall) begin
			if (bit_cnt_reg == 3'h0 && (phase_reg == PH_DATA)) begin
				case (opcode_reg)
					OP_STATUS_FETCH: shift_out_reg <= status_view; // RULE_08
					OP_ARRAY_FETCH, OP_FAST_ARRAY_FETCH, OP_OTP_FETCH: shift_out_reg <= rd_data; // RULE_04 RULE_18
					default: shift_out_reg <= 8'h00;
				endcase
				sdo_oe_n_reg <= !(opcode_reg == OP_STATUS_FETCH || opcode_reg == OP_ARRAY_FETCH ||
					opcode_reg == OP_FAST_ARRAY_FETCH || (opcode_reg == OP_OTP_FETCH &&
					count_reg < 7'(OTP_BYTES)));
				sdo_reg <= (opcode_reg == OP_STATUS_FETCH) ? status_view[7] : rd_data[7]; // RULE_02
			end else begin
				sdo_reg <= shift_out_reg[~bit_cnt_reg]; // RULE_20
			end
		end
	end
	assign link.sdo_o = sdo_reg;
	assign link.sdo_oe_n = sdo_oe_n_reg;
	assign opcode = opcode_reg;
	assign address = addr_reg;
	assign wr_data = wr_data_reg;
	assign wr_strobe = wr_strobe_reg;
	assign status_one = status_view;
	assign status_two = status_two_reg;
endmodule : spi_nvm_device

/* File: hw/spi_nvm_master.sv */
// controller end: apb-driven serial byte engine
`timescale 1ns/1ns
module spi_nvm_master
	import spi_nvm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	spi_nvm_if.master link
);
	// ----------------------------------------------------------------
	// registers and bus slave
	// ----------------------------------------------------------------
	logic select_reg, wp_reg, busy_reg, start;
	logic [7:0] rx_reg, tx_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic [2:0] sdo_sync_reg;
	logic sdo_f_reg;
	logic acc;
	assign acc = psel && penable;
	assign start = acc && pwrite && paddr == REG_TXDATA && !busy_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			select_reg <= 1'b0;
			wp_reg <= 1'b1;
			tx_reg <= 8'h00;
		end else if (acc && pwrite) begin
			if (paddr == REG_CTRL) begin
				select_reg <= pwdata[CTRL_SELECT_BIT];
				wp_reg <= pwdata[1];
			end
			if (start) tx_reg <= pwdata[7:0];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_reg <= !(paddr == REG_CTRL || paddr == REG_TXDATA ||
				paddr == REG_RXDATA || paddr == REG_STAT);
			case (paddr)
				REG_CTRL: prdata_reg <= {30'h0, wp_reg, select_reg};
				REG_RXDATA: prdata_reg <= {24'h0, rx_reg};
				REG_STAT: prdata_reg <= {31'h0, busy_reg};
				default: prdata_reg <= 32'h00000000;
			endcase
		end
	end
	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = pslverr_reg;
	// ----------------------------------------------------------------
	// byte shifter, mode 0, msb first
	// ----------------------------------------------------------------
	logic [3:0] bit_cnt_reg;
	logic [2:0] div_reg;
	logic sck_reg, sdi_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdo_sync_reg <= 3'h0;
			sdo_f_reg <= 1'b0;
		end else begin
			sdo_sync_reg <= {sdo_sync_reg[1:0], link.sdo};
			if (sdo_sync_reg[1] == sdo_sync_reg[2]) sdo_f_reg <= sdo_sync_reg[2];
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
			div_reg <= 3'h0;
			sck_reg <= 1'b0;
			sdi_reg <= 1'b0;
			rx_reg <= 8'h00;
		end else if (start) begin
			busy_reg <= 1'b1;
			bit_cnt_reg <= 4'h0;
			div_reg <= 3'h0;
			sdi_reg <= pwdata[7];
		end else if (busy_reg) begin
			div_reg <= div_reg + 3'h1;
			if (div_reg == 3'(SCK_HALF_DIV - 1)) begin
				div_reg <= 3'h0;
				sck_reg <= !sck_reg;
				if (!sck_reg) begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end else begin
					// answer taken at the fall: by then it has crossed both synchronisers
					rx_reg <= {rx_reg[6:0], sdo_f_reg}; // RULE_02
					if (bit_cnt_reg == 4'h8) busy_reg <= 1'b0;
					else sdi_reg <= tx_reg[3'(4'h7 - bit_cnt_reg)]; // RULE_02
				end
			end
		end
	end
	assign link.cs_n = !select_reg;
	assign link.sck = sck_reg;
	assign link.sdi = sdi_reg;
	assign link.wp_n = wp_reg;
endmodule : spi_nvm_master

/* File: bench/spi_nvm_props.sv */
// link checker for the serial memory interface
`timescale 1ns/1ns
module spi_nvm_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	input wire logic sdo_oe_n
);
	// ----------------------------------------------------------------
	// helper: serial clock rises within one selection
	// ----------------------------------------------------------------
	logic sck_q;
	logic [15:0] rise_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sck_q <= 1'b0;
		else sck_q <= sck;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) rise_cnt <= 16'h0000;
		else if (cs_n) rise_cnt <= 16'h0000;
		else if (sck && !sck_q) rise_cnt <= rise_cnt + 16'h0001;
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_high_phase;
		sck [*6];
	endsequence
	sequence s_low_phase;
		!sck;
	endsequence
	property p_half_period;
		$rose(sck) |-> s_high_phase ##1 s_low_phase;
	endproperty
	property p_whole_bytes;
		$rose(cs_n) |-> rise_cnt[2:0] == 3'h0;
	endproperty
	property p_select_clock_low;
		$fell(cs_n) |-> !sck;
	endproperty
	property p_clock_only_selected;
		sck |-> !cs_n;
	endproperty
	property p_sdi_moves_low;
		$changed(sdi) |-> !sck;
	endproperty
	property p_release_after_deselect;
		$rose(cs_n) |-> ##[1:8] sdo_oe_n;
	endproperty
	property p_stay_released;
		cs_n [*8] |-> sdo_oe_n;
	endproperty
	property p_drive_only_selected;
		$fell(sdo_oe_n) |-> !cs_n;
	endproperty
	a_half_period: assert property (p_half_period) else $error("sck high phase wrong");
	a_whole_bytes: assert property (p_whole_bytes) else $error("partial byte framed");
	a_select_clock_low: assert property (p_select_clock_low) else $error("sck high at select");
	a_clock_only_selected: assert property (p_clock_only_selected) else $error("sck while idle");
	a_sdi_moves_low: assert property (p_sdi_moves_low) else $error("sdi moved with sck high");
	a_release_after_deselect: assert property (p_release_after_deselect) else $error("sdo held");
	a_stay_released: assert property (p_stay_released) else $error("sdo driven while idle");
	a_drive_only_selected: assert property (p_drive_only_selected) else $error("sdo driven early");
endmodule : spi_nvm_props

/* File: bench/spi_eeprom_command_status_tb.sv */
// testbench: apb-driven controller talking to the memory device end
`timescale 1ns/1ns
module spi_eeprom_command_status_tb
	import spi_nvm_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata, q;
	logic pready, pslverr, err, wr_strobe;
	logic wp = 1'b1;
	logic [7:0] rd_data = 8'h00;
	logic [7:0] opcode, wr_data, status_one, status_two, sdi_sr, sdo_sr;
	logic [7:0] got [$];
	logic [7:0] ce [2] = '{OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
	int miscompares = 0;
	int comparisons = 0;
	int strobes = 0;
	always #20 pclk = ~pclk;
	spi_nvm_if link_i ();
	spi_nvm_device spi_nvm_device_i (.pclk(pclk), .presetn(presetn), .link(link_i.device),
		.opcode(opcode), .address(), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_data(rd_data),
		.status_one(status_one), .status_two(status_two));
	spi_nvm_master spi_nvm_master_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link_i.master));
	spi_nvm_props spi_nvm_props_i (.pclk(pclk), .presetn(presetn), .cs_n(link_i.cs_n),
		.sck(link_i.sck), .sdi(link_i.sdi), .sdo_oe_n(link_i.sdo_oe_n));
	// ----------------------------------------------------------------
	// wire monitors
	// ----------------------------------------------------------------
	always @(posedge link_i.sck) begin
		if (!link_i.cs_n) begin
			sdi_sr <= {sdi_sr[6:0], link_i.sdi};
			sdo_sr <= {sdo_sr[6:0], link_i.sdo};
		end
	end
	always @(posedge pclk) begin
		if (wr_strobe === 1'b1) strobes++;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic complete_run;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : complete_run
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic limit(input int n, input int lim);
		if (n >= lim) begin
			miscompares++;
			complete_run();
		end
	endtask : limit
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		limit(n, 50);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic xfer(input logic [7:0] b);
		int n;
		apb(1'b1, REG_TXDATA, {24'h000000, b});
		n = 0;
		do begin
			apb(1'b0, REG_STAT, 32'h00000000);
			n++;
		end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 100);
		limit(n, 100);
		apb(1'b0, REG_RXDATA, 32'h00000000);
		got.push_back(q[7:0]);
	endtask : xfer
	task automatic run(input logic [7:0] b [$]);
		got.delete();
		apb(1'b1, REG_CTRL, {30'h00000000, wp, 1'b1});
		foreach (b[i]) xfer(b[i]);
		apb(1'b1, REG_CTRL, {30'h00000000, wp, 1'b0});
	endtask : run
	task automatic stat(input logic [7:0] e, input logic [7:0] m);
		run('{OP_STATUS_FETCH, 8'h00, 8'h00});
		check(got[1] & m, e);
		check(got[2] & m, e);
		check(sdo_sr & m, e);
	endtask : stat
	task automatic wait_idle;
		int n;
		repeat (8) @(posedge pclk);
		n = 0;
		while (status_one[BUSY_FLAG_BIT] !== 1'b0 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		limit(n, 300);
	endtask : wait_idle
	task automatic busy_cycle;
		int n;
		n = 0;
		while (status_one[BUSY_FLAG_BIT] !== 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		check(status_one[BUSY_FLAG_BIT], 1'b1);
		wait_idle();
	endtask : busy_cycle
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(status_one, STATUS_ONE_RESET);
		check(status_two, STATUS_TWO_RESET);
		apb(1'b0, 8'h10, 32'h00000000);
		check(err, 1'b1);
		stat(8'h00, 8'hFF);
		run('{OP_SET_WRITE_LATCH});
		check(sdi_sr, OP_SET_WRITE_LATCH);
		stat(8'h02, 8'hFF);
		run('{OP_CLEAR_WRITE_LATCH});
		stat(8'h00, 8'hFF);
		run('{OP_STATUS_LOAD_FIRST, 8'h8C});
		stat(8'h00, 8'hFF);
		run('{OP_SET_WRITE_LATCH});
		run('{OP_STATUS_LOAD_FIRST, 8'h9F});
		wait_idle();
		stat(8'h8C, 8'hFF);
		wp = 1'b0;
		run('{OP_SET_WRITE_LATCH});
		run('{OP_STATUS_LOAD_FIRST, 8'h00});
		wait_idle();
		stat(8'h8C, 8'hFD);
		wp = 1'b1;
		run('{OP_SET_WRITE_LATCH});
		run('{OP_STATUS_LOAD_FIRST, 8'h00});
		wait_idle();
		stat(8'h00, 8'hFF);
		run('{OP_SET_WRITE_LATCH});
		run('{OP_STATUS_LOAD_SECOND, 8'hFF});
		wait_idle();
		check(status_two, STATUS_TWO_WRITABLE);
		strobes = 0;
		run('{OP_SET_WRITE_LATCH});
		run('{OP_ARRAY_PROGRAM, 8'h12, 8'h34, 8'hA1, 8'hB2, 8'hC3});
		check(opcode, OP_ARRAY_PROGRAM);
		check(wr_data, 8'hC3);
		busy_cycle();
		check(strobes, 3);
		stat(8'h00, 8'hFF);
		foreach (ce[i]) begin
			run('{OP_SET_WRITE_LATCH});
			run('{ce[i]});
			busy_cycle();
		end
		run('{OP_SET_WRITE_LATCH});
		run('{OP_PAGE_ERASE, 8'h00, 8'h20});
		busy_cycle();
		rd_data <= 8'h5A;
		run('{OP_ARRAY_FETCH, 8'h00, 8'h10, 8'h00, 8'h00});
		check(got[3], 8'h5A);
		check(got[4], 8'h5A);
		rd_data <= 8'hC3;
		run('{OP_FAST_ARRAY_FETCH, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00});
		check(got[4], 8'hC3);
		check(got[5], 8'hC3);
		run('{OP_OTP_FETCH, 8'h00, 8'h00});
		check(got[2], 8'hC3);
		run('{OP_SET_WRITE_LATCH});
		run('{OP_OTP_PROGRAM, 8'h11, 8'h22, 8'h33});
		check(opcode, OP_OTP_PROGRAM);
		wait_idle();
		run('{OP_SLEEP_ENTER});
		stat(8'hFF, 8'hFF);
		run('{OP_SET_WRITE_LATCH});
		run('{OP_WAKE_FROM_SLEEP});
		stat(8'h00, 8'hFF);
		run('{OP_ULTRA_DEEP_SLEEP});
		stat(8'hFF, 8'hFF);
		check(status_one[ULTRA_DEEP_BIT], 1'b1);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(status_one[ULTRA_DEEP_BIT], 1'b0);
		stat(8'h00, 8'hFF);
		complete_run();
	end
endmodule : spi_eeprom_command_status_tb
